// ---- design/link_monitor_map.svh ----
`ifndef LINK_MONITOR_MAP_SVH
`define LINK_MONITOR_MAP_SVH
// Register indices; byte address is four times the index
`define LQM_IDX_CONFIG    14'h0560
`define LQM_IDX_COUNTERS  14'h0561
`define LQM_IDX_TRAINING  14'h0562
`define LQM_IDX_IRQ_STAT  14'h0570
`define LQM_IDX_IRQ_CLR   14'h0571
`define LQM_IDX_IRQ_EN    14'h0572
// Reset values
`define LQM_CFG_RESET     14'h07E4
`define LQM_CNT_RESET     16'h0000
// Link-up selector codes
`define LQM_SEL_STD       2'h0
`define LQM_SEL_MONITOR   2'h1
`define LQM_SEL_SEND_DATA 2'h2
`define LQM_SEL_COMM      2'h3
// Hysteresis timer codes and times in microseconds
`define LQM_HYST_2MS      2'h0
`define LQM_HYST_500US    2'h1
`define LQM_HYST_1MS      2'h2
`define LQM_HYST_4MS      2'h3
`define LQM_T_2MS_US      2000
`define LQM_T_500US_US    500
`define LQM_T_1MS_US      1000
`define LQM_T_4MS_US      4000
`define LQM_CLK_MHZ       50
// Counter limits and bus answers
`define LQM_LOSS_MAX      6'h3F
`define LQM_FAIL_MAX      10'h3FF
`define LQM_RESP_OKAY     2'h0
`define LQM_RESP_DECERR   2'h3
`endif

// ---- design/link_monitor_pkg.sv ----
`default_nettype none
package link_monitor_pkg;
   // Writable configuration fields, packed as in the config register
   typedef struct packed {
      logic       spare;      // Reserved writable bit
      logic [1:0] metric;     // Link-up selector
      logic [5:0] mask;       // Failure scenario enables
      logic [1:0] timer_sel;  // Hysteresis choice
      logic [2:0] sqi_thr;    // Bad SQI threshold
   } cfg_t;
   // Failure event pulses from the receive path
   typedef struct packed {
      logic bad_end;                    // Bad end delimiter
      logic rx_error;                   // Receive error
      logic link_dropped_event;         // Link_dropped_event
      logic bad_stream_start;           // Bad start-of-stream
      logic receive_overlength_detect;  // Receive jabber
   } fail_events_t;
   // Interrupt sources
   typedef struct packed {
      logic comm_change;  // Comm ready toggled
      logic failure;      // Failure logged
      logic loss;         // Link lost
   } irq_t;
endpackage
`default_nettype wire

// ---- design/link_quality_monitor.sv ----
// Functional notes
// - Two-bit selector picks monitored link-up signal
// - Six-bit failure enable mask, resets all ones
// - Mask bit 0: log SQI worse than threshold
// - Mask bit 1: log jabber or bad start
// - Two-bit hysteresis timer for comm ready
// - SQI threshold resets four, bumps failure counter
// - Six-bit link loss counter, cleared at power-up
// - Ten-bit failure-without-loss counter, power-up clear
// - Read-only comm ready flag for upper layers
// - Read-only last link training time, resets zero
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "link_monitor_map.svh"

module link_quality_monitor #(
   parameter int HYST_2MS_CYC   = `LQM_T_2MS_US * `LQM_CLK_MHZ,
   parameter int HYST_500US_CYC = `LQM_T_500US_US * `LQM_CLK_MHZ,
   parameter int HYST_1MS_CYC   = `LQM_T_1MS_US * `LQM_CLK_MHZ,
   parameter int HYST_4MS_CYC   = `LQM_T_4MS_US * `LQM_CLK_MHZ
) (
   input  wire logic                          clk_sys,
   input  wire logic                          rst_n,
   // AXI4-Lite slave
   input  wire logic [15:0]                   s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [15:0]                   s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   // PHY status inputs
   input  wire logic                          link_up_std,
   input  wire logic                          link_monitor_status,
   input  wire logic                          phy_send_data,
   input  wire logic [2:0]                    sqi_value,
   input  wire link_monitor_pkg::fail_events_t fail_events,
   input  wire logic                          training_done,
   input  wire logic [7:0]                    training_time,
   // Status outputs
   output logic                               comm_ready,
   output logic                               irq
);

   // ----------------------------------------
   // Reset synchroniser
   // ----------------------------------------
   logic rst_meta_n;  // First stage
   logic rst_sync_n;  // Released reset

   // Async assert, two-flop release
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_sync_n);

   // ----------------------------------------
   // State
   // ----------------------------------------
   link_monitor_pkg::cfg_t cfg_reg;        // Config fields
   logic [5:0]             loss_cnt_reg;   // Link losses
   logic [9:0]             fail_cnt_reg;   // Failures without loss
   logic [7:0]             train_reg;      // Last training time
   logic                   comm_ready_reg; // Hysteresis output
   logic [17:0]            hyst_cnt_reg;   // Hysteresis counter
   logic [17:0]            hyst_limit;     // Selected hold time
   logic                   link_sel;       // Monitored link-up
   logic                   link_prev_reg;  // Last cycle's link-up
   logic                   sqi_bad_reg;    // Last cycle's SQI state
   logic                   sqi_bad;        // SQI worse than threshold
   logic                   fail_hit;       // Enabled failure this cycle
   logic                   loss_hit;       // Link dropped this cycle
   link_monitor_pkg::irq_t irq_stat_reg;   // Sticky status
   link_monitor_pkg::irq_t irq_en_reg;     // Enables
   link_monitor_pkg::irq_t irq_set;        // Events this cycle
   logic                   wr_go;          // Write taken
   logic                   rd_go;          // Read taken
   logic [13:0]            wr_idx;         // Write index
   logic [13:0]            rd_idx;         // Read index

   // Index in range of a register
   function automatic logic is_mapped(input logic [13:0] idx);
      is_mapped = (idx == `LQM_IDX_CONFIG) || (idx == `LQM_IDX_COUNTERS) ||
                  (idx == `LQM_IDX_TRAINING) || (idx == `LQM_IDX_IRQ_STAT) ||
                  (idx == `LQM_IDX_IRQ_CLR) || (idx == `LQM_IDX_IRQ_EN);
   endfunction

   // ----------------------------------------
   // Link selection and event detection
   // ----------------------------------------
   // Monitored link-up signal
   always_comb begin
      unique case (cfg_reg.metric)
         `LQM_SEL_STD:       link_sel = link_up_std;
         `LQM_SEL_MONITOR:   link_sel = link_monitor_status;
         `LQM_SEL_SEND_DATA: link_sel = phy_send_data;
         `LQM_SEL_COMM:      link_sel = comm_ready_reg;
      endcase
   end

   assign sqi_bad  = sqi_value > cfg_reg.sqi_thr;
   assign loss_hit = link_prev_reg && !link_sel;
   // Enabled scenarios, counted only while the link holds
   assign fail_hit = link_prev_reg && link_sel &&
                     ((cfg_reg.mask[0] && sqi_bad && !sqi_bad_reg) ||
                      (cfg_reg.mask[1] && (fail_events.receive_overlength_detect ||
                                           fail_events.bad_stream_start)) ||
                      (cfg_reg.mask[2] && fail_events.link_dropped_event) ||
                      (cfg_reg.mask[3] && fail_events.rx_error) ||
                      (cfg_reg.mask[4] && fail_events.bad_end));

   // Edge history
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         link_prev_reg <= 1'b0;
         sqi_bad_reg   <= 1'b0;
      end else begin
         link_prev_reg <= link_sel;
         sqi_bad_reg   <= sqi_bad;
      end
   end

   // ----------------------------------------
   // Counters, cleared only by reset
   // ----------------------------------------
   // Link loss counter
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         loss_cnt_reg <= 6'(`LQM_CNT_RESET);
      end else if (loss_hit && loss_cnt_reg != `LQM_LOSS_MAX) begin
         loss_cnt_reg <= loss_cnt_reg + 6'h01;
      end
   end

   // Failure counter
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         fail_cnt_reg <= 10'(`LQM_CNT_RESET);
      end else if (fail_hit && fail_cnt_reg != `LQM_FAIL_MAX) begin
         fail_cnt_reg <= fail_cnt_reg + 10'h001;
      end
   end

   // Last training duration capture
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         train_reg <= 8'(`LQM_CNT_RESET);
      end else if (training_done) begin
         train_reg <= training_time;
      end
   end

   // ----------------------------------------
   // Comm ready hysteresis
   // ----------------------------------------
   // Hold time from selector
   always_comb begin
      unique case (cfg_reg.timer_sel)
         `LQM_HYST_2MS:   hyst_limit = 18'(HYST_2MS_CYC);
         `LQM_HYST_500US: hyst_limit = 18'(HYST_500US_CYC);
         `LQM_HYST_1MS:   hyst_limit = 18'(HYST_1MS_CYC);
         `LQM_HYST_4MS:   hyst_limit = 18'(HYST_4MS_CYC);
      endcase
   end

   // Rises after link stays up for the hold time, drops at once
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hyst_cnt_reg   <= 18'h00000;
         comm_ready_reg <= 1'b0;
      end else if (!link_up_std) begin
         hyst_cnt_reg   <= 18'h00000;
         comm_ready_reg <= 1'b0;
      end else if (!comm_ready_reg) begin
         if (hyst_cnt_reg + 18'h00001 >= hyst_limit) begin
            comm_ready_reg <= 1'b1;
            hyst_cnt_reg   <= 18'h00000;
         end else begin
            hyst_cnt_reg <= hyst_cnt_reg + 18'h00001;
         end
      end
   end

   assign comm_ready = comm_ready_reg;

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign irq_set.loss        = loss_hit && loss_cnt_reg != `LQM_LOSS_MAX;
   assign irq_set.failure     = fail_hit && fail_cnt_reg != `LQM_FAIL_MAX;
   assign irq_set.comm_change = link_up_std ? (!comm_ready_reg &&
                                hyst_cnt_reg + 18'h00001 >= hyst_limit) : comm_ready_reg;

   // Sticky status; set wins over clear
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_stat_reg <= 3'h0;
      end else if (wr_go && wr_idx == `LQM_IDX_IRQ_CLR && s_axi_wstrb[0]) begin
         irq_stat_reg <= (irq_stat_reg & ~s_axi_wdata[2:0]) | irq_set;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_set;
      end
   end

   assign irq = |(irq_stat_reg & irq_en_reg);

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   assign wr_go         = rst_sync_n && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign wr_idx        = s_axi_awaddr[15:2];

   // Config and enable registers, byte lanes honoured
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cfg_reg    <= `LQM_CFG_RESET;
         irq_en_reg <= 3'h0;
      end else if (wr_go) begin
         if (wr_idx == `LQM_IDX_CONFIG) begin
            if (s_axi_wstrb[0]) begin
               cfg_reg[7:0] <= s_axi_wdata[7:0];
            end
            if (s_axi_wstrb[1]) begin
               cfg_reg[13:8] <= s_axi_wdata[13:8];
            end
         end else if (wr_idx == `LQM_IDX_IRQ_EN && s_axi_wstrb[0]) begin
            irq_en_reg <= s_axi_wdata[2:0];
         end
      end
   end

   // Write response
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `LQM_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= is_mapped(wr_idx) ? `LQM_RESP_OKAY : `LQM_RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   assign rd_go         = rst_sync_n && s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = rd_go;
   assign rd_idx        = s_axi_araddr[15:2];

   // Read data mux and response
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `LQM_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= is_mapped(rd_idx) ? `LQM_RESP_OKAY : `LQM_RESP_DECERR;
         unique case (rd_idx)
            `LQM_IDX_CONFIG:   s_axi_rdata <= {18'h00000, cfg_reg};
            `LQM_IDX_COUNTERS: s_axi_rdata <= {16'h0000, loss_cnt_reg, fail_cnt_reg};
            `LQM_IDX_TRAINING: s_axi_rdata <= {16'h0000, comm_ready_reg, 7'h00,
                                               train_reg};
            `LQM_IDX_IRQ_STAT: s_axi_rdata <= {29'h00000000, irq_stat_reg};
            `LQM_IDX_IRQ_EN:   s_axi_rdata <= {29'h00000000, irq_en_reg};
            default:           s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_select_comm: assert property ((cfg_reg.metric == `LQM_SEL_COMM) |->
      (link_sel == comm_ready_reg)) else $error("selector does not follow comm ready");

   a_mask_gate: assert property ((!link_prev_reg || cfg_reg.mask == 6'h00) |=>
      $stable(fail_cnt_reg)) else $error("failure counted with gate closed");

   a_sqi_log: assert property ((cfg_reg.mask[0] && sqi_bad && !sqi_bad_reg &&
      link_prev_reg && link_sel && fail_cnt_reg != `LQM_FAIL_MAX) |=>
      fail_cnt_reg == $past(fail_cnt_reg) + 10'h001) else $error("sqi failure missed");

   a_jabber_log: assert property ((cfg_reg.mask[1] && link_prev_reg && link_sel &&
      fail_events.receive_overlength_detect && fail_cnt_reg != `LQM_FAIL_MAX) |=>
      fail_cnt_reg == $past(fail_cnt_reg) + 10'h001) else $error("jabber failure missed");

   a_comm_drop: assert property (!link_up_std |=> !comm_ready_reg)
      else $error("comm ready held without link");

   a_comm_rise: assert property ($rose(comm_ready_reg) |->
      ($past(hyst_cnt_reg) + 18'h00001 >= $past(hyst_limit)))
      else $error("comm ready rose early");

   a_loss_count: assert property ((loss_hit && loss_cnt_reg != `LQM_LOSS_MAX) |=>
      loss_cnt_reg == $past(loss_cnt_reg) + 6'h01) else $error("link loss not counted");

   a_fail_loss: assert property (loss_hit |=> $stable(fail_cnt_reg))
      else $error("failure counted during link loss");

   a_count_sat: assert property ((loss_cnt_reg == `LQM_LOSS_MAX) |=>
      (loss_cnt_reg == `LQM_LOSS_MAX)) else $error("loss counter wrapped");

   a_train_cap: assert property (training_done |=>
      train_reg == $past(training_time)) else $error("training time not captured");

endmodule

`default_nettype wire

// ---- sim/tb_link_quality_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "link_monitor_map.svh"

module tb_link_quality_monitor;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic                          clk_sys       = 1'b0;  // 50 MHz system clock
   logic                          rst_n         = 1'b0;  // Held low at start
   logic [15:0]                   s_axi_awaddr  = 16'h0000;
   logic                          s_axi_awvalid = 1'b0;
   logic                          s_axi_awready;
   logic [31:0]                   s_axi_wdata   = 32'h0000_0000;
   logic [3:0]                    s_axi_wstrb   = 4'hF;
   logic                          s_axi_wvalid  = 1'b0;
   logic                          s_axi_wready;
   logic [1:0]                    s_axi_bresp;
   logic                          s_axi_bvalid;
   logic                          s_axi_bready  = 1'b1;  // Always ready for answers
   logic [15:0]                   s_axi_araddr  = 16'h0000;
   logic                          s_axi_arvalid = 1'b0;
   logic                          s_axi_arready;
   logic [31:0]                   s_axi_rdata;
   logic [1:0]                    s_axi_rresp;
   logic                          s_axi_rvalid;
   logic                          s_axi_rready  = 1'b1;
   logic [2:0]                    lnk           = 3'h0;  // Std, monitor, send-data
   logic [2:0]                    sqi           = 3'h0;  // Signal quality
   link_monitor_pkg::fail_events_t ev           = '0;    // Failure pulses
   logic                          training_done = 1'b0;
   logic [7:0]                    training_time = 8'h00;
   logic                          comm_ready;
   logic                          irq;
   int                            errors          = 0;
   int                            samples_checked = 0;
   logic [5:0]                    exp_loss = 6'h00;  // Expected loss count
   logic [9:0]                    exp_fail = 10'h000;  // Expected failure count
   // Byte addresses
   localparam logic [15:0] A_CFG = {`LQM_IDX_CONFIG, 2'h0};
   localparam logic [15:0] A_CNT = {`LQM_IDX_COUNTERS, 2'h0};
   localparam logic [15:0] A_TRN = {`LQM_IDX_TRAINING, 2'h0};
   localparam logic [15:0] A_STS = {`LQM_IDX_IRQ_STAT, 2'h0};
   localparam logic [15:0] A_CLR = {`LQM_IDX_IRQ_CLR, 2'h0};
   localparam logic [15:0] A_EN  = {`LQM_IDX_IRQ_EN, 2'h0};

   // Clock
   always #10 clk_sys = ~clk_sys;

   // ----------------------------------------
   // Device under test, short hysteresis counts
   // ----------------------------------------
   link_quality_monitor #(.HYST_2MS_CYC(20), .HYST_500US_CYC(5), .HYST_1MS_CYC(10),
      .HYST_4MS_CYC(40)) link_quality_monitor_i (
      .clk_sys(clk_sys), .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .link_up_std(lnk[0]), .link_monitor_status(lnk[1]), .phy_send_data(lnk[2]),
      .sqi_value(sqi), .fail_events(ev), .training_done(training_done),
      .training_time(training_time), .comm_ready(comm_ready), .irq(irq));

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Write: address and data offered together, each released when taken
   task automatic bus_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      begin
         aw_done = 1'b0;
         w_done  = 1'b0;
         s_axi_awaddr  <= a;
         s_axi_wdata   <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid  <= 1'b1;
         while (!(aw_done && w_done)) begin
            @(posedge clk_sys);
            if (!aw_done && s_axi_awready) begin
               aw_done = 1'b1;
               s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
               w_done = 1'b1;
               s_axi_wvalid <= 1'b0;
            end
         end
         // Wait until the write response is valid
         do begin
            @(posedge clk_sys);
         end while (!s_axi_bvalid);
         r = s_axi_bresp;
      end
   endtask

   // Read: address offered until taken, then wait for data
   task automatic bus_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge clk_sys);
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [1:0] r;
      begin
         bus_wr(a, d, r);
         check({30'h0, r}, {30'h0, `LQM_RESP_OKAY});
      end
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      begin
         bus_rd(a, d, r);
         check({30'h0, r}, {30'h0, `LQM_RESP_OKAY});
         check(d, exp);
      end
   endtask

   // Config word: selector, mask, timer, threshold four
   function automatic logic [31:0] cfg(input logic [1:0] s, input logic [5:0] m,
                                       input logic [1:0] t);
      cfg = {18'h0, 1'b0, s, m, t, 3'h4};
   endfunction

   // Saturating expected counts
   task automatic bump_loss;
      if (exp_loss != `LQM_LOSS_MAX) exp_loss = exp_loss + 6'h01;
   endtask
   task automatic bump_fail;
      if (exp_fail != `LQM_FAIL_MAX) exp_fail = exp_fail + 10'h001;
   endtask
   task automatic cnt_chk;
      rd_chk(A_CNT, {16'h0, exp_loss, exp_fail});
   endtask

   task automatic lnk_pulse(input int k);
      lnk[k] <= 1'b1;
      tick(3);
      lnk[k] <= 1'b0;
      tick(3);
   endtask
   task automatic ev_pulse(input int b);
      ev <= link_monitor_pkg::fail_events_t'(5'h01 << b);
      tick(1);
      ev <= '0;
      tick(1);
   endtask
   task automatic sqi_pulse(input logic [2:0] v);
      sqi <= v;
      tick(1);
      sqi <= 3'h0;
      tick(1);
   endtask
   // Fire the source of mask bit i, return how many failures it makes
   task automatic fire(input int i, output int n);
      n = 1;
      if (i == 0) begin
         sqi_pulse(3'h4);
         sqi_pulse(3'h5);
      end else if (i == 1) begin
         ev_pulse(0);
         ev_pulse(1);
         n = 2;
      end else begin
         ev_pulse(i);
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd_chk(A_CFG, {18'h0, `LQM_CFG_RESET});
      cnt_chk();
      rd_chk(A_TRN, 32'h0);
      check({31'h0, comm_ready | irq}, 32'h0);
   endtask

   task automatic t_bus;
      logic [31:0] d;
      logic [1:0]  r;
      begin
         wr(A_CFG, 32'hFFFF_FFFF);
         rd_chk(A_CFG, 32'h0000_3FFF);
         // Low lane only: upper config bits must survive
         s_axi_wstrb <= 4'h1;
         wr(A_CFG, 32'h0000_0000);
         s_axi_wstrb <= 4'hF;
         rd_chk(A_CFG, 32'h0000_3F00);
         wr(A_CNT, 32'h0000_FFFF);
         cnt_chk();
         bus_wr(16'h1000, 32'h1, r);
         check({30'h0, r}, {30'h0, `LQM_RESP_DECERR});
         bus_rd(16'h1000, d, r);
         check({30'h0, r}, {30'h0, `LQM_RESP_DECERR});
         check(d, 32'h0);
      end
   endtask

   task automatic t_train;
      training_time <= 8'hA5;
      training_done <= 1'b1;
      tick(1);
      training_done <= 1'b0;
      training_time <= 8'h3C;
      tick(2);
      rd_chk(A_TRN, 32'h0000_00A5);
   endtask

   task automatic t_select;
      for (int s = 0; s < 3; s++) begin
         wr(A_CFG, cfg(s[1:0], 6'h00, 2'h1));
         for (int k = 0; k < 3; k++) lnk_pulse(k);
         bump_loss();
         cnt_chk();
      end
      wr(A_CFG, cfg(2'h3, 6'h00, 2'h1));
      lnk_pulse(1);
      lnk[0] <= 1'b1;
      tick(12);
      lnk[0] <= 1'b0;
      tick(3);
      bump_loss();
      cnt_chk();
   endtask

   task automatic t_fail;
      int n;
      begin
         lnk[0] <= 1'b1;
         tick(3);
         for (int i = 0; i < 5; i++) begin
            wr(A_CFG, cfg(2'h0, 6'h01 << i, 2'h1));
            fire(i, n);
            repeat (n) bump_fail();
            cnt_chk();
            wr(A_CFG, cfg(2'h0, 6'h3F ^ (6'h01 << i), 2'h1));
            fire(i, n);
            cnt_chk();
         end
         lnk[0] <= 1'b0;
         tick(3);
         bump_loss();
         cnt_chk();
      end
   endtask

   task automatic t_hyst;
      int lim[4];
      int n;
      begin
         lim = '{20, 5, 10, 40};
         for (int t = 0; t < 4; t++) begin
            wr(A_CFG, cfg(2'h0, 6'h00, t[1:0]));
            lnk[0] <= 1'b1;
            n = 0;
            do begin
               tick(1);
               n++;
            end while (comm_ready !== 1'b1 && n < 100);
            // Flag is read before the edge's update, so seen one edge after it rises
            check(n, lim[t] + 1);
            rd_chk(A_TRN, 32'h0000_80A5);
            lnk[0] <= 1'b0;
            tick(3);
            bump_loss();
            check({31'h0, comm_ready}, 32'h0);
         end
         cnt_chk();
      end
   endtask

   task automatic t_irq;
      wr(A_CLR, 32'h7);
      wr(A_EN, 32'h1);
      wr(A_CFG, cfg(2'h0, 6'h00, 2'h1));
      lnk_pulse(0);
      bump_loss();
      check({31'h0, irq}, 32'h1);
      rd_chk(A_STS, 32'h1);
      wr(A_EN, 32'h0);
      check({31'h0, irq}, 32'h0);
      wr(A_EN, 32'h1);
      check({31'h0, irq}, 32'h1);
      wr(A_CLR, 32'h1);
      check({31'h0, irq}, 32'h0);
      rd_chk(A_STS, 32'h0);
   endtask

   task automatic t_sat;
      wr(A_CFG, cfg(2'h0, 6'h08, 2'h1));
      lnk[0] <= 1'b1;
      tick(3);
      repeat (1030) begin
         ev_pulse(3);
         bump_fail();
      end
      lnk[0] <= 1'b0;
      tick(3);
      bump_loss();
      repeat (70) begin
         lnk_pulse(0);
         bump_loss();
      end
      cnt_chk();
      rd_chk(A_CNT, {16'h0, `LQM_LOSS_MAX, `LQM_FAIL_MAX});
   endtask

   // ----------------------------------------
   // Verdict, watchdog and main sequence
   // ----------------------------------------
   task automatic test_done;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Cut a hang short
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      test_done();
   end

   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      tick(4);
      t_reset();
      t_bus();
      t_train();
      t_select();
      t_fail();
      t_hyst();
      t_irq();
      t_sat();
      test_done();
   end
endmodule
`default_nettype wire
